// ===== core/annp_axil_slave.sv
// module: axi4-lite slave turning bus transfers into single-cycle register strobes
`timescale 1ns/10ps
`default_nettype none
module annp_axil_slave (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // register side
  annp_reg_if.slave        regs
);
  logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]  aw_addr_q, aw_addr_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0]  w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic        do_wr, do_rd;
  logic        awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;

  // write fires once both halves held and no response pending
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign do_rd = arvalid && !rvalid_q;

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_addr_d = aw_addr_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      aw_addr_d = awaddr;
    end
    if (wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      w_data_d = wdata;
      w_strb_d = wstrb;
    end
    if (do_wr) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = regs.wr_ok ? annp_pkg::RESP_OKAY : annp_pkg::RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_rd) begin
      rvalid_d = 1'b1;
      rdata_d  = regs.rd_data;
      rresp_d  = regs.rd_ok ? annp_pkg::RESP_OKAY : annp_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    // ready flags registered so bus outputs come straight from flops
    awready_d = !aw_have_d;
    wready_d  = !w_have_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      rvalid_q  <= 1'b0;
      rresp_q   <= 2'h0;
      rdata_q   <= 32'h0000_0000;
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      aw_addr_q <= aw_addr_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
    end
  end

  assign awready       = awready_q;
  assign wready        = wready_q;
  assign arready       = arready_q;
  assign bvalid        = bvalid_q;
  assign bresp         = bresp_q;
  assign rvalid        = rvalid_q;
  assign rresp         = rresp_q;
  assign rdata         = rdata_q;
  assign regs.wr_en    = do_wr;
  assign regs.wr_addr  = aw_addr_q;
  assign regs.wr_data  = w_data_q;
  assign regs.wr_strb  = w_strb_q;
  assign regs.rd_en    = do_rd;
  assign regs.rd_addr  = araddr;
endmodule
`default_nettype wire

// ===== core/annp_pkg.sv
// package: register map, field positions and reset values of the next-page status block
// Functional notes
// - acknowledge bit driven only by negotiation logic
// - bit 13 message page flag, RO, reset 0
// - bit 12 partner can comply, RO, reset 0
// - bit 11 toggle, inverse of previous toggle
// - bits 10:0 partner code field, RO, reset 0
// - expansion bits 15:5 ignore writes, read 0
// - bit 4 parallel detection fault, reset 0
// - bit 3 partner next page capable
// - bit 2 local next page capable, fixed 1
// - bit 1 page received, clear on read
// - bit 0 partner negotiation capable, reset 0
// - next-page word at register index 05h, bus address 14h
// - bit 15 partner wants more pages
package annp_pkg;
  localparam logic [7:0]  IDX_PARTNER_WORD  = 8'h05;
  localparam logic [7:0]  IDX_EXPANSION     = 8'h06;
  localparam logic [7:0]  ADDR_PARTNER_WORD = {IDX_PARTNER_WORD[5:0], 2'b00};
  localparam logic [7:0]  ADDR_EXPANSION    = {IDX_EXPANSION[5:0], 2'b00};
  localparam logic [7:0]  ADDR_IRQ_STATUS   = 8'h40;
  localparam logic [7:0]  ADDR_IRQ_ENABLE   = 8'h44;
  localparam logic [7:0]  ADDR_IRQ_CLEAR    = 8'h48;
  localparam int          BIT_MORE_PAGES    = 15;
  localparam int          BIT_ACK           = 14;
  localparam int          BIT_MESSAGE_PAGE  = 13;
  localparam int          BIT_COMPLY        = 12;
  localparam int          BIT_TOGGLE        = 11;
  localparam int          BIT_PD_FAULT      = 4;
  localparam int          BIT_LP_PAGES      = 3;
  localparam int          BIT_LOCAL_PAGES   = 2;
  localparam int          BIT_PAGE_RX       = 1;
  localparam int          BIT_LP_AN         = 0;
  localparam logic [15:0] RST_PARTNER_WORD  = 16'h0000;
  localparam logic        RST_LOCAL_PAGES   = 1'b1;
  localparam int          IRQ_W             = 3;
  localparam int          IRQ_PAGE          = 0;
  localparam int          IRQ_FAULT         = 1;
  localparam int          IRQ_LP_AN         = 2;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

// ===== core/annp_reg_core.sv
// module: next-page word, expansion status and interrupt registers
`timescale 1ns/10ps
`default_nettype none
module annp_reg_core (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // negotiation logic
  input  wire logic        page_load,
  input  wire logic        more_pages_wanted,
  input  wire logic        ack_in,
  input  wire logic        message_page_flag,
  input  wire logic        partner_can_comply,
  input  wire logic        prev_toggle,
  input  wire logic [10:0] code_field,
  input  wire logic        page_received,
  input  wire logic        parallel_detect_fault,
  input  wire logic        partner_pages_capable,
  input  wire logic        partner_negotiation_capable,
  // register access
  annp_reg_if.core         regs,
  // status out
  output var  logic        irq,
  output var  logic [15:0] word_out
);
  logic [15:0]                  word_q, word_d;
  logic                         page_rx_q, page_rx_d;
  logic                         fault_q, fault_d, lp_np_q, lp_np_d, lp_an_q, lp_an_d;
  logic [annp_pkg::IRQ_W-1:0]   ista_q, ista_d, ien_q, ien_d, iev, iclr;
  logic                         irq_q, irq_d;
  logic [15:0]                  exp_word;
  logic                         exp_rd;
  logic                         fault_prev_q, lp_an_prev_q;

  // expansion register image; upper bits stay zero
  always_comb begin
    exp_word = 16'h0000;
    exp_word[annp_pkg::BIT_PD_FAULT]    = fault_q;
    exp_word[annp_pkg::BIT_LP_PAGES]    = lp_np_q;
    exp_word[annp_pkg::BIT_LOCAL_PAGES] = annp_pkg::RST_LOCAL_PAGES;
    exp_word[annp_pkg::BIT_PAGE_RX]     = page_rx_q;
    exp_word[annp_pkg::BIT_LP_AN]       = lp_an_q;
  end

  assign exp_rd = regs.rd_en && (regs.rd_addr == annp_pkg::ADDR_EXPANSION);

  // read decode
  always_comb begin
    regs.rd_ok   = 1'b1;
    regs.rd_data = 32'h0000_0000;
    case (regs.rd_addr)
      annp_pkg::ADDR_PARTNER_WORD: regs.rd_data = {16'h0000, word_q};
      annp_pkg::ADDR_EXPANSION:    regs.rd_data = {16'h0000, exp_word};
      annp_pkg::ADDR_IRQ_STATUS:   regs.rd_data = {29'h0, ista_q};
      annp_pkg::ADDR_IRQ_ENABLE:   regs.rd_data = {29'h0, ien_q};
      annp_pkg::ADDR_IRQ_CLEAR:    regs.rd_data = 32'h0000_0000;
      default:                     regs.rd_ok   = 1'b0;
    endcase
  end

  // writes to status registers are accepted and ignored
  always_comb begin
    case (regs.wr_addr)
      annp_pkg::ADDR_PARTNER_WORD,
      annp_pkg::ADDR_EXPANSION,
      annp_pkg::ADDR_IRQ_STATUS,
      annp_pkg::ADDR_IRQ_ENABLE,
      annp_pkg::ADDR_IRQ_CLEAR: regs.wr_ok = 1'b1;
      default:                  regs.wr_ok = 1'b0;
    endcase
  end

  always_comb begin
    word_d = word_q;
    // whole word loads at once, only from negotiation logic
    if (page_load) begin
      word_d = {more_pages_wanted, ack_in, message_page_flag, partner_can_comply,
                !prev_toggle, code_field};
    end
    fault_d = parallel_detect_fault;
    lp_np_d = partner_pages_capable;
    lp_an_d = partner_negotiation_capable;
    // set wins over clear-on-read
    page_rx_d = page_received ? 1'b1 : (exp_rd ? 1'b0 : page_rx_q);
    iev = '0;
    iev[annp_pkg::IRQ_PAGE]  = page_received;
    iev[annp_pkg::IRQ_FAULT] = fault_q && !fault_prev_q;
    iev[annp_pkg::IRQ_LP_AN] = lp_an_q && !lp_an_prev_q;
    iclr = '0;
    ien_d = ien_q;
    if (regs.wr_en && regs.wr_strb[0]) begin
      if (regs.wr_addr == annp_pkg::ADDR_IRQ_CLEAR)
        iclr = regs.wr_data[annp_pkg::IRQ_W-1:0];
      if (regs.wr_addr == annp_pkg::ADDR_IRQ_ENABLE)
        ien_d = regs.wr_data[annp_pkg::IRQ_W-1:0];
    end
    ista_d = iev | (ista_q & ~iclr);
    irq_d  = |(ista_d & ien_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q       <= annp_pkg::RST_PARTNER_WORD;
      page_rx_q    <= 1'b0;
      fault_q      <= 1'b0;
      lp_np_q      <= 1'b0;
      lp_an_q      <= 1'b0;
      fault_prev_q <= 1'b0;
      lp_an_prev_q <= 1'b0;
      ista_q       <= '0;
      ien_q        <= '0;
      irq_q        <= 1'b0;
    end else begin
      word_q       <= word_d;
      page_rx_q    <= page_rx_d;
      fault_q      <= fault_d;
      lp_np_q      <= lp_np_d;
      lp_an_q      <= lp_an_d;
      fault_prev_q <= fault_q;
      lp_an_prev_q <= lp_an_q;
      ista_q       <= ista_d;
      ien_q        <= ien_d;
      irq_q        <= irq_d;
    end
  end

  assign irq      = irq_q;
  assign word_out = word_q;
endmodule
`default_nettype wire

// ===== core/annp_reg_if.sv
// interface: register access strobes between bus slave and register core
`timescale 1ns/10ps
`default_nettype none
interface annp_reg_if;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_ok;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_ok;
  modport slave (output rd_en, rd_addr, wr_en, wr_addr, wr_data, wr_strb,
                 input rd_data, rd_ok, wr_ok);
  modport core (input rd_en, rd_addr, wr_en, wr_addr, wr_data, wr_strb,
                output rd_data, rd_ok, wr_ok);
endinterface
`default_nettype wire

// ===== core/annp_top.sv
// module: top of the next-page status register block
`timescale 1ns/10ps
`default_nettype none
module annp_top (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // negotiation logic
  input  wire logic        page_load,
  input  wire logic        more_pages_wanted,
  input  wire logic        ack_in,
  input  wire logic        message_page_flag,
  input  wire logic        partner_can_comply,
  input  wire logic        prev_toggle,
  input  wire logic [10:0] code_field,
  input  wire logic        page_received,
  input  wire logic        parallel_detect_fault,
  input  wire logic        partner_pages_capable,
  input  wire logic        partner_negotiation_capable,
  // interrupt and status
  output var  logic        irq,
  output var  logic [15:0] partner_next_page_word
);
  annp_reg_if regs ();

  annp_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (regs)
  );

  annp_reg_core u_core (
    .aclk                        (aclk),
    .aresetn                     (aresetn),
    .page_load                   (page_load),
    .more_pages_wanted           (more_pages_wanted),
    .ack_in                      (ack_in),
    .message_page_flag           (message_page_flag),
    .partner_can_comply          (partner_can_comply),
    .prev_toggle                 (prev_toggle),
    .code_field                  (code_field),
    .page_received               (page_received),
    .parallel_detect_fault       (parallel_detect_fault),
    .partner_pages_capable       (partner_pages_capable),
    .partner_negotiation_capable (partner_negotiation_capable),
    .regs                        (regs),
    .irq                         (irq),
    .word_out                    (partner_next_page_word)
  );
endmodule
`default_nettype wire

// ===== test/annp_checker.sv
// checker: read path and page load behaviour of the next-page status block, with only a cover on the interrupt
`timescale 1ns/10ps
`default_nettype none
module annp_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // read channels
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // negotiation logic
  input wire logic        page_load,
  input wire logic        more_pages_wanted,
  input wire logic        ack_in,
  input wire logic        message_page_flag,
  input wire logic        partner_can_comply,
  input wire logic        prev_toggle,
  input wire logic [10:0] code_field,
  input wire logic        page_received,
  input wire logic        parallel_detect_fault,
  input wire logic        partner_pages_capable,
  input wire logic        partner_negotiation_capable,
  // status
  input wire logic        irq,
  input wire logic [15:0] partner_next_page_word
);
  logic [7:0]  ra_q;
  logic [15:0] word_q;
  logic        pend_q;
  logic        rx_q;
  logic        tk;
  logic        ex;
  logic        wd;
  logic        um;
  assign tk = arvalid && arready && araddr == annp_pkg::ADDR_EXPANSION;
  assign ex = ra_q == annp_pkg::ADDR_EXPANSION;
  assign wd = ra_q == annp_pkg::ADDR_PARTNER_WORD;
  assign um = !(ra_q inside {8'h14, 8'h18, 8'h40, 8'h44, 8'h48});
  // expected word, last read address and page-received shadow
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ra_q   <= 8'h00;
      word_q <= 16'h0000;
      pend_q <= 1'b0;
      rx_q   <= 1'b0;
    end else begin
      if (arvalid && arready) ra_q <= araddr;
      if (tk) rx_q <= pend_q;
      if (page_received) pend_q <= 1'b1;
      else if (tk) pend_q <= 1'b0;
      if (page_load) word_q <= {more_pages_wanted, ack_in, message_page_flag,
                                partner_can_comply, !prev_toggle, code_field};
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  word_load_a: assert property (page_load |-> ##1
    partner_next_page_word == word_q)
    else $error("next-page word not loaded from page fields");
  word_hold_a: assert property (!page_load && !$past(page_load)
    |=> $stable(partner_next_page_word))
    else $error("next-page word changed without a page load");
  resv_zero_a: assert property ($rose(rvalid) && ex |->
    rdata[31:5] == 27'h0 && rdata[2])
    else $error("expansion upper bits or local capability wrong");
  exp_levels_a: assert property ($rose(rvalid) && ex |->
    rdata[4] == $past(parallel_detect_fault, 2) && rdata[3] == $past(partner_pages_capable, 2)
    && rdata[0] == $past(partner_negotiation_capable, 2))
    else $error("expansion status levels wrong");
  page_rx_a: assert property ($rose(rvalid) && ex |-> rdata[1] == rx_q)
    else $error("page received bit wrong");
  word_read_a: assert property ($rose(rvalid) && wd |->
    rdata == {16'h0000, $past(partner_next_page_word)})
    else $error("next-page word read wrong");
  unmapped_a: assert property ($rose(rvalid) && um |->
    rresp == annp_pkg::RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped before taken");
  page_c: cover property (page_load);
  rx_c: cover property ($rose(rvalid) && ex && rdata[1]);
  irq_c: cover property ($rose(irq));
endmodule
bind annp_top annp_checker annp_checker_i (.aclk, .aresetn, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .page_load, .more_pages_wanted, .ack_in,
  .message_page_flag, .partner_can_comply, .prev_toggle, .code_field, .page_received,
  .parallel_detect_fault, .partner_pages_capable, .partner_negotiation_capable, .irq,
  .partner_next_page_word);
`default_nettype wire

// ===== test/annp_nego_model.sv
// model: negotiation logic handing received pages and link levels to the block
`timescale 1ns/10ps
`default_nettype none
module annp_nego_model (
  // clock
  input  wire logic        aclk,
  // page fields
  output var  logic        page_load,
  output var  logic        page_received,
  output wire logic        more_pages_wanted,
  output wire logic        ack_in,
  output wire logic        message_page_flag,
  output wire logic        partner_can_comply,
  output wire logic        prev_toggle,
  output wire logic [10:0] code_field,
  // link levels
  output wire logic        parallel_detect_fault,
  output wire logic        partner_pages_capable,
  output wire logic        partner_negotiation_capable
);
  logic [15:0] f_q = 16'h0000;
  logic [2:0]  lv_q = 3'h0;
  initial page_load = 1'b0;
  initial page_received = 1'b0;
  // ack comes from this logic only; all fields change with the load pulse
  assign {more_pages_wanted, ack_in, message_page_flag, partner_can_comply,
          prev_toggle, code_field} = f_q;
  assign {parallel_detect_fault, partner_pages_capable, partner_negotiation_capable} = lv_q;
  // f[11] carries the previous toggle; fields show junk outside the pulse
  task automatic send_page(input logic [15:0] f);
    @(posedge aclk);
    f_q <= f;
    page_load <= 1'b1;
    page_received <= 1'b1;
    @(posedge aclk);
    f_q <= ~f;
    page_load <= 1'b0;
    page_received <= 1'b0;
  endtask
  task automatic set_levels(input logic [2:0] l);
    @(posedge aclk);
    lv_q <= l;
  endtask
endmodule
`default_nettype wire

// ===== test/annp_top_tb_top.sv
// testbench: register reads, page loads and interrupts of the next-page status block
`timescale 1ns/10ps
`default_nettype none
module annp_top_tb_top;
  localparam logic [7:0] WRD = annp_pkg::ADDR_PARTNER_WORD;
  localparam logic [7:0] EXP = annp_pkg::ADDR_EXPANSION;
  localparam logic [7:0] STA = annp_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] ENA = annp_pkg::ADDR_IRQ_ENABLE;
  localparam logic [7:0] CLR = annp_pkg::ADDR_IRQ_CLEAR;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd_data;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_resp, wr_resp;
  logic [15:0] partner_next_page_word;
  wire logic   page_load, page_received, more_pages_wanted, ack_in, message_page_flag;
  wire logic   partner_can_comply, prev_toggle, parallel_detect_fault;
  wire logic   partner_pages_capable, partner_negotiation_capable;
  wire logic [10:0] code_field;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [15:0] pg [4] = '{16'hA5A5, 16'h5A5A, 16'hFFFF, 16'h0000};
  annp_top annp_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .page_load, .more_pages_wanted, .ack_in, .message_page_flag, .partner_can_comply,
    .prev_toggle, .code_field, .page_received, .parallel_detect_fault, .partner_pages_capable,
    .partner_negotiation_capable, .irq, .partner_next_page_word);
  annp_nego_model annp_nego_model_i (.aclk, .page_load, .page_received, .more_pages_wanted,
    .ack_in, .message_page_flag, .partner_can_comply, .prev_toggle, .code_field,
    .parallel_detect_fault, .partner_pages_capable, .partner_negotiation_capable);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  // handshakes are judged on values seen before the rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      wr_resp = bresp;
      @(posedge aclk);
      if (ta) {awvalid, awaddr} <= {1'b0, ~a};
      if (tw) {wvalid, wdata} <= {1'b0, ~d};
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    tv = 1'b0;
    while (!tv) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tv = rvalid && rready;
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge aclk);
      if (ta) {arvalid, araddr} <= {1'b0, ~a};
    end
    rready <= 1'b0;
  endtask
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (4) @(posedge aclk);
    wstrb <= 4'hF;
    aresetn <= 1'b1;
    rd(EXP); chk(rd_data, 32'h0000_0004);
    chk({30'h0, rd_resp}, {30'h0, annp_pkg::RESP_OKAY});
    rd(WRD); chk(rd_data, 32'h0);
    rd(8'h20); chk({30'h0, rd_resp}, {30'h0, annp_pkg::RESP_SLVERR});
    wr(8'h30, 32'h1); chk({30'h0, wr_resp}, {30'h0, annp_pkg::RESP_SLVERR});
    wr(EXP, 32'hFFFF_FFFF); chk({30'h0, wr_resp}, {30'h0, annp_pkg::RESP_OKAY});
    rd(EXP); chk(rd_data, 32'h0000_0004);
    // the word register is never written: hardware owns its acknowledge bit
    foreach (pg[i]) begin
      annp_nego_model_i.send_page(pg[i]);
      rd(WRD); chk(rd_data, {16'h0, pg[i] ^ 16'h0800});
    end
    chk({16'h0, partner_next_page_word}, 32'h0000_0800);
    rd(EXP); chk(rd_data, 32'h0000_0006);
    rd(EXP); chk(rd_data, 32'h0000_0004);
    annp_nego_model_i.set_levels(3'b111);
    repeat (3) @(posedge aclk);
    rd(EXP); chk(rd_data, 32'h0000_001D);
    annp_nego_model_i.set_levels(3'b000);
    repeat (3) @(posedge aclk);
    rd(EXP); chk(rd_data, 32'h0000_0004);
    rd(STA); chk(rd_data, 32'h7);
    chk_irq(1'b0);
    wr(ENA, 32'h7); chk_irq(1'b1);
    wr(CLR, 32'h7); chk_irq(1'b0);
    wr(STA, 32'h7); rd(STA); chk(rd_data, 32'h0);
    rd(CLR); chk(rd_data, 32'h0);
    wr(ENA, 32'h6); annp_nego_model_i.send_page(16'h1234); chk_irq(1'b0);
    rd(STA); chk(rd_data, 32'h1);
    rd(ENA); chk(rd_data, 32'h6);
    wr(ENA, 32'h7); chk_irq(1'b1);
    wr(CLR, 32'h1); chk_irq(1'b0);
    // enable write without its low byte strobe must leave the enables alone
    wstrb <= 4'h0;
    wr(ENA, 32'h0);
    wstrb <= 4'hF;
    rd(ENA); chk(rd_data, 32'h7);
    conclude();
  end
endmodule
`default_nettype wire
